//--- pkg/cprc_params.svh
`ifndef CPRC_PARAMS_SVH
`define CPRC_PARAMS_SVH
// power-on delay figures, in microseconds, and the clock rate they count at
`define CPRC_DELAY_LONG_US   100000
`define CPRC_DELAY_SHORT_US  2000
`define CPRC_CLK_MHZ         40
`define CPRC_DELAY_LONG_CYC  (`CPRC_DELAY_LONG_US * `CPRC_CLK_MHZ)
`define CPRC_DELAY_SHORT_CYC (`CPRC_DELAY_SHORT_US * `CPRC_CLK_MHZ)
// default page after reset, and the half-period of the configuration clock in clock cycles
`define CPRC_PAGE_DEFAULT    3'h0
`define CPRC_CLK_DIV_DEFAULT 8'h02
// data words to send before the done signal must have risen
`define CPRC_WORDS_DEFAULT   32'h0000_1000
// cycles spent in arm before the line level is trusted: two sync stages and one
`define CPRC_SETTLE_CYC      2'h3
`endif

//--- pkg/cprc_pkg.sv
package cprc_pkg;
  typedef enum logic [4:0] {
    CPRC_RESET  = 5'h01,
    CPRC_ARM    = 5'h02,
    CPRC_CONFIG = 5'h04,
    CPRC_DONE   = 5'h08,
    CPRC_IDLE   = 5'h10
  } cprc_state_e;
endpackage

//--- logic/cprc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module cprc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_in,
  input  wire logic             reset_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage_reg;

  // the first stage is read only by the second
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      stage_reg <= '0;
      sync_out  <= '0;
    end
    else
    begin
      stage_reg <= async_in;
      sync_out  <= stage_reg;
    end
  end
endmodule // cprc_sync
`default_nettype wire

//--- logic/cprc_reset_control.sv
// How it works
// R1: three-bit page select picks one of eight
// R2: bit 2 is msb; page zero default
// R3: system drives page select, never floating
// R4: optional external clock sources configuration clock
// R5: delay select low 100 ms, high 2 ms
// R6: hold enable low until supply and delay
// R7: external low on enable extends reset
// R8: host waits for reset end before scan
// R9: supply drop restarts full power-on delay
// R10: fpga status low forces reset
// R11: done low after all data restarts
// R12: factory test pins tied low and high
// R13: chip select high at release idles until supply drops
// R14: delay counter sized for both delays
`timescale 1ns/1ps
`default_nettype none
`include "cprc_params.svh"
module cprc_reset_control #(
  parameter int unsigned LONG_CYC  = `CPRC_DELAY_LONG_CYC,
  parameter int unsigned SHORT_CYC = `CPRC_DELAY_SHORT_CYC,
  parameter int unsigned WORDS     = `CPRC_WORDS_DEFAULT,
  parameter logic [7:0]  CLK_DIV   = `CPRC_CLK_DIV_DEFAULT
) (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       reset_in,
  // board straps and supply
  input  wire logic       supply_good_in,
  input  wire logic       reset_delay_select_in,
  input  wire logic [2:0] page_select_in,
  input  wire logic       ext_clock_in,
  input  wire logic       ext_clock_select_in,
  // fpga side
  input  wire logic       fpga_status_n_in,
  input  wire logic       fpga_done_in,
  input  wire logic       chip_select_n_in,
  // shared open-drain enable line
  input  wire logic       enable_line_in,
  output logic            enable_line_out,
  output logic            enable_line_oe_out,
  // configuration outputs
  output logic            config_clock_out,
  output logic            config_data_valid_out,
  output logic [2:0]      page_out,
  output logic            in_reset_out,
  output logic            config_error_out
);
  logic [8:0]  sync_w;
  logic        supply_s, dsel_s, ext_s, extsel_s, status_s, done_s, cs_s, line_s;
  logic [2:0]  page_s;
  cprc_pkg::cprc_state_e state_reg;
  logic [31:0] delay_cnt_reg;
  logic [31:0] word_cnt_reg;
  logic [7:0]  div_cnt_reg;
  logic        int_clk_reg;
  logic        ext_prev_reg;
  logic        tick;
  logic [1:0]  settle_reg;

  cprc_sync #(.WIDTH(9)) u_sync (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .async_in ({supply_good_in, reset_delay_select_in, ext_clock_in, ext_clock_select_in,
                fpga_status_n_in, fpga_done_in, chip_select_n_in, enable_line_in,
                page_select_in[0]}),
    .sync_out (sync_w)
  );
  assign {supply_s, dsel_s, ext_s, extsel_s, status_s, done_s, cs_s, line_s} = sync_w[8:1];

  cprc_sync #(.WIDTH(2)) u_sync_page (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .async_in (page_select_in[2:1]),
    .sync_out (page_s[2:1])
  );
  assign page_s[0] = sync_w[0];

  function automatic logic [31:0] delay_for(input logic sel);
    // high selects the short delay
    return sel ? 32'(SHORT_CYC) : 32'(LONG_CYC); // [R5]
  endfunction

  // clock source: divided internal clock or edges of the external clock
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      div_cnt_reg  <= 8'h00;
      int_clk_reg  <= 1'b0;
      ext_prev_reg <= 1'b0;
    end
    else
    begin
      ext_prev_reg <= ext_s;
      if (div_cnt_reg >= CLK_DIV - 8'h01)
      begin
        div_cnt_reg <= 8'h00;
        int_clk_reg <= ~int_clk_reg;
      end
      else
      begin
        div_cnt_reg <= div_cnt_reg + 8'h01;
      end
    end
  end
  // one tick per rising edge of the chosen source
  assign tick = extsel_s ? (ext_s & ~ext_prev_reg) // [R4]
                         : (div_cnt_reg >= CLK_DIV - 8'h01) & ~int_clk_reg;

  // our own low pulse reaches line_s two cycles late; without this wait its
  // tail would read as an outside hold and restart reset over and over
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
      settle_reg <= 2'h0;
    else if (state_reg != cprc_pkg::CPRC_ARM)
      settle_reg <= 2'h0;
    else if (settle_reg != `CPRC_SETTLE_CYC)
      settle_reg <= settle_reg + 2'h1; // [R7]
  end

  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      state_reg     <= cprc_pkg::CPRC_RESET; // [R9]
      delay_cnt_reg <= 32'h0;
      word_cnt_reg  <= 32'h0;
    end
    else if (!supply_s)
    begin
      // supply loss restarts the full delay
      state_reg     <= cprc_pkg::CPRC_RESET; // [R9]
      delay_cnt_reg <= 32'h0;
    end
    else
    begin
      case (state_reg)
        cprc_pkg::CPRC_RESET:
        begin
          // counter counts every clk_in cycle, compared to the selected count
          if (delay_cnt_reg >= delay_for(dsel_s) - 32'h1) // [R14] [R6]
            state_reg <= cprc_pkg::CPRC_ARM;
          else
            delay_cnt_reg <= delay_cnt_reg + 32'h1;
        end
        cprc_pkg::CPRC_ARM:
        begin
          // enable released; wait for the line to actually rise
          if (line_s && settle_reg == `CPRC_SETTLE_CYC) // [R7]
          begin
            word_cnt_reg <= 32'h0;
            // idle is sticky until the next power cycle
            if (cs_s)
              state_reg <= cprc_pkg::CPRC_IDLE; // [R13]
            else
              state_reg <= cprc_pkg::CPRC_CONFIG;
          end
        end
        cprc_pkg::CPRC_CONFIG:
        begin
          if (!status_s || !line_s)
          begin
            state_reg     <= cprc_pkg::CPRC_RESET; // [R10] [R7]
            delay_cnt_reg <= delay_for(dsel_s) - 32'h1;
          end
          else if (done_s)
            state_reg <= cprc_pkg::CPRC_DONE;
          else if (word_cnt_reg >= 32'(WORDS))
          begin
            state_reg     <= cprc_pkg::CPRC_RESET; // [R11]
            delay_cnt_reg <= delay_for(dsel_s) - 32'h1;
          end
          else if (tick)
            word_cnt_reg <= word_cnt_reg + 32'h1;
        end
        cprc_pkg::CPRC_DONE:
        begin
          if (!status_s || !line_s)
          begin
            state_reg     <= cprc_pkg::CPRC_RESET; // [R10] [R7]
            delay_cnt_reg <= delay_for(dsel_s) - 32'h1;
          end
        end
        cprc_pkg::CPRC_IDLE:
          state_reg <= cprc_pkg::CPRC_IDLE; // [R13]
        default:
          state_reg <= cprc_pkg::CPRC_RESET;
      endcase
    end
  end

  // page is latched while in reset so it cannot change mid-load
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
      page_out <= `CPRC_PAGE_DEFAULT; // [R2]
    else if (state_reg == cprc_pkg::CPRC_RESET)
      page_out <= page_s; // [R1] [R2]
  end

  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      enable_line_out       <= 1'b0;
      enable_line_oe_out    <= 1'b1;
      config_clock_out      <= 1'b0;
      config_data_valid_out <= 1'b0;
      in_reset_out          <= 1'b1;
      config_error_out      <= 1'b0;
    end
    else
    begin
      enable_line_out       <= 1'b0;
      // drive low only in reset; released otherwise, outside party may pull low
      enable_line_oe_out    <= (state_reg == cprc_pkg::CPRC_RESET) || !supply_s; // [R6]
      in_reset_out          <= (state_reg == cprc_pkg::CPRC_RESET) ||
                               (state_reg == cprc_pkg::CPRC_ARM) || !supply_s; // [R7]
      config_data_valid_out <= (state_reg == cprc_pkg::CPRC_CONFIG) && tick && supply_s;
      // clock stays static outside configuration and once the supply drops
      if (state_reg == cprc_pkg::CPRC_CONFIG && supply_s) // [R6]
        config_clock_out <= extsel_s ? ext_s : int_clk_reg; // [R4]
      else
        config_clock_out <= 1'b0; // [R13]
      if (state_reg == cprc_pkg::CPRC_CONFIG && !done_s && word_cnt_reg >= 32'(WORDS))
        config_error_out <= 1'b1; // [R11]
      else if (state_reg == cprc_pkg::CPRC_DONE)
        config_error_out <= 1'b0;
    end
  end
endmodule // cprc_reset_control
`default_nettype wire

//--- bench/cprc_fpga_model.sv
`timescale 1ns/1ps
`default_nettype none
module cprc_fpga_model #(
  parameter int DONE_AT = 8
) (
  // clock and device outputs
  input  wire logic clk_in,
  input  wire logic valid_in,
  input  wire logic oe_in,
  // bench controls
  input  wire logic hold_in,
  input  wire logic stall_done_in,
  // wire level and status
  output logic      line_out,
  output logic      done_out,
  output int        ticks_out
);
  // pull-up on the shared line, low while either party pulls it
  assign line_out = !(oe_in || hold_in);
  always_ff @(posedge clk_in)
  begin
    if (!line_out)
      ticks_out <= 0;
    else if (valid_in)
      ticks_out <= ticks_out + 1;
  end
  // stalling keeps done low so the device must detect the failure
  assign done_out = !stall_done_in && (ticks_out >= DONE_AT);
endmodule // cprc_fpga_model
`default_nettype wire

//--- bench/cprc_reset_control_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module cprc_reset_control_asserts (
  input wire logic       clk_in,
  input wire logic       reset_in,
  input wire logic       supply_good_in,
  input wire logic       fpga_status_n_in,
  input wire logic       enable_line_in,
  input wire logic       enable_line_out,
  input wire logic       enable_line_oe_out,
  input wire logic       config_clock_out,
  input wire logic       config_data_valid_out,
  input wire logic [2:0] page_out,
  input wire logic       in_reset_out,
  input wire logic       config_error_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  AST_SUPPLY_LOSS: assert property (!supply_good_in |-> ##[1:5] enable_line_oe_out)
    else $error("enable not driven after supply loss");
  AST_DELAY_HOLD: assert property ($rose(supply_good_in) |-> enable_line_oe_out [*8])
    else $error("enable released before delay");
  AST_RELEASE_GOOD: assert property ($fell(enable_line_oe_out) |-> supply_good_in)
    else $error("enable released with supply bad");
  AST_DRIVE_LOW: assert property (enable_line_out == 1'b0)
    else $error("enable line driven high");
  AST_PAGE_HELD: assert property (!in_reset_out && !$past(in_reset_out) |-> $stable(page_out))
    else $error("page changed outside reset");
  AST_STATUS: assert property ($fell(fpga_status_n_in) |-> ##[1:6] enable_line_oe_out)
    else $error("status low did not reset");
  AST_ERROR_RESTART: assert property ($rose(config_error_out) |-> ##[0:2] enable_line_oe_out)
    else $error("error without restart");
  AST_LINE_HOLD: assert property (!enable_line_in [*6] |-> !config_data_valid_out)
    else $error("data sent while line low");
  AST_QUIET_RESET: assert property (in_reset_out |-> !config_clock_out && !config_data_valid_out)
    else $error("clock active in reset");
endmodule // cprc_reset_control_asserts
bind cprc_reset_control cprc_reset_control_asserts u_asserts (.clk_in(clk_in),
  .reset_in(reset_in), .supply_good_in(supply_good_in), .fpga_status_n_in(fpga_status_n_in),
  .enable_line_in(enable_line_in), .enable_line_out(enable_line_out),
  .enable_line_oe_out(enable_line_oe_out), .config_clock_out(config_clock_out),
  .config_data_valid_out(config_data_valid_out), .page_out(page_out),
  .in_reset_out(in_reset_out), .config_error_out(config_error_out));
`default_nettype wire

//--- bench/tb_config_por_reset_control.sv
`timescale 1ns/1ps
`default_nettype none
module tb_config_por_reset_control;
  logic clk_in = 0, reset_in = 1, sg = 0, dsel = 1, ext_clk = 0, ext_sel = 0, st_n = 1;
  logic cs_n = 0, hold = 0, stall = 0, seen_oe = 0;
  logic [2:0] pg = 3'h5, page_o; // page straps always driven
  // factory test straps are board ties outside this block's pins
  logic line, eo, oe, cclk, valid, inrst, err, done;
  int   ticks, num_checks = 0, fails = 0;
  initial forever #12.5 clk_in = ~clk_in;
  // external clock, unrelated in phase to clk_in
  always #90 ext_clk = ~ext_clk;
  always @(posedge clk_in) if (oe === 1'b1) seen_oe <= 1'b1;
  cprc_reset_control #(.LONG_CYC(50), .SHORT_CYC(10), .WORDS(16)) u_cprc_reset_control (
    .clk_in(clk_in), .reset_in(reset_in), .supply_good_in(sg), .reset_delay_select_in(dsel),
    .page_select_in(pg), .ext_clock_in(ext_clk), .ext_clock_select_in(ext_sel),
    .fpga_status_n_in(st_n), .fpga_done_in(done), .chip_select_n_in(cs_n),
    .enable_line_in(line), .enable_line_out(eo), .enable_line_oe_out(oe),
    .config_clock_out(cclk), .config_data_valid_out(valid), .page_out(page_o),
    .in_reset_out(inrst), .config_error_out(err));
  cprc_fpga_model #(.DONE_AT(8)) u_cprc_fpga_model (.clk_in(clk_in), .valid_in(valid),
    .oe_in(oe), .hold_in(hold), .stall_done_in(stall), .line_out(line), .done_out(done),
    .ticks_out(ticks));
  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #2;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    step(5);
    check("reset oe", oe, 1);
    check("reset page", page_o, 3'h0);
    reset_in = 0;
    sg = 1;
    step(8);
    check("short hold", oe, 1);
    step(14);
    check("short release", oe, 0);
    for (int i = 0; i < 100 && done !== 1'b1; i++) step(1);
    step(20);
    check("page", page_o, 3'h5);
    // one more pulse leaves while done crosses the synchroniser
    check("done ticks", ticks, 9);
    $display("test short delay done");
    hold = 1;
    sg = 0;
    step(10);
    check("supply loss", inrst, 1);
    dsel = 0;
    sg = 1;
    step(40);
    check("long hold", oe, 1);
    step(30);
    check("long release", oe, 0);
    check("held by line", inrst, 1);
    hold = 0;
    step(12);
    check("line free", inrst, 0);
    $display("test hold done");
    seen_oe = 0;
    st_n = 0;
    step(1);
    st_n = 1;
    step(8);
    check("status reset", seen_oe, 1);
    $display("test status done");
    ext_sel = 1;
    stall = 1;
    for (int i = 0; i < 400 && err !== 1'b1; i++) step(1);
    check("error", err, 1);
    stall = 0;
    // let the restart pulse clear the stale tick count first
    step(4);
    for (int i = 0; i < 400 && done !== 1'b1; i++) step(1);
    step(6);
    check("ext clock done", done, 1);
    check("error clear", err, 0);
    $display("test error done");
    cs_n = 1;
    sg = 0;
    step(6);
    dsel = 1;
    sg = 1;
    step(80);
    check("idle release", oe, 0);
    check("idle ticks", ticks, 0);
    check("idle clock", cclk, 0);
    $display("test idle done");
    complete_run();
  end
  initial
  begin
    repeat (4000) @(posedge clk_in);
    fails++;
    complete_run();
  end
endmodule // tb_config_por_reset_control
`default_nettype wire
